// file: verif/wdhrc_asserts.sv
// Port assertions for the watchdog, halt and reset block
`timescale 1ns/1ns
module wdhrc_asserts (
	input logic sys_clk,
	input logic arst_n,
	input logic optWdtEnable,
	input logic haltInstr,
	input logic coreHold,
	input logic halted,
	input logic timeout_flag,
	input logic powerdown_flag,
	input logic warmReset,
	input logic chipReset,
	input logic resumeNext,
	input logic [7:0] regAddr,
	input logic [7:0] regRdData,
	input logic [7:0] watchdog_select_reg,
	input logic [7:0] portDataReset
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic [10:0] wakeCnt_q;
	// Length of the current hold outside halt, so halt time never pads the count
	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			wakeCnt_q <= 11'h000;
		else
			wakeCnt_q <= (halted || !coreHold) ? 11'h000 : wakeCnt_q + 11'h001;
	property p_hlt; haltInstr && !coreHold |=> halted && powerdown_flag && !timeout_flag; endproperty
	a_hlt: assert property (p_hlt) else $error("halt");
	property p_wrm; warmReset |-> ##[0:1] timeout_flag && powerdown_flag; endproperty
	a_wrm: assert property (p_wrm) else $error("warm flags");
	property p_one; warmReset |=> !warmReset && !halted && !chipReset; endproperty
	a_one: assert property (p_one) else $error("warm");
	property p_hold; chipReset |-> coreHold && portDataReset == 8'hff; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_watchdog_select; chipReset ##1 chipReset |-> watchdog_select_reg == 8'h07; endproperty
	a_watchdog_select: assert property (p_watchdog_select) else $error("watchdog_select");
	property p_rd; regRdData == (regAddr == 8'h09 ? watchdog_select_reg : 8'h00); endproperty
	a_rd: assert property (p_rd) else $error("read");
	property p_dis; !optWdtEnable |=> !$rose(timeout_flag); endproperty
	a_dis: assert property (p_dis) else $error("off");
	property p_dly; resumeNext |-> wakeCnt_q > 11'h3fa && wakeCnt_q < 11'h406; endproperty
	a_dly: assert property (p_dly) else $error("delay");
endmodule // wdhrc_asserts
bind wdhrc_watchdog_halt_reset_ctrl wdhrc_asserts chk (
	.sys_clk(sys_clk),
	.arst_n(arst_n),
	.optWdtEnable(optWdtEnable),
	.haltInstr(haltInstr),
	.coreHold(coreHold),
	.halted(halted),
	.timeout_flag(timeout_flag),
	.powerdown_flag(powerdown_flag),
	.warmReset(warmReset),
	.chipReset(chipReset),
	.resumeNext(resumeNext),
	.regAddr(regAddr),
	.regRdData(regRdData),
	.watchdog_select_reg(watchdog_select_reg),
	.portDataReset(portDataReset)
);

// file: verif/wdhrc_core_model.sv
// Core model issuing clear and halt instruction pulses
`timescale 1ns/1ns
module wdhrc_core_model (
	input logic sys_clk,
	input logic coreHold,
	input logic [1:0] req,
	output logic haltInstr = 1'h0,
	output logic watchdog_clear_single = 1'h0,
	output logic watchdog_clear_first = 1'h0,
	output logic watchdog_clear_second = 1'h0
);
	// A held core executes nothing
	always @(posedge sys_clk)
	begin
		haltInstr <= #2 req == 2'h1 && !coreHold;
		watchdog_clear_single <= #2 req == 2'h2 && !coreHold;
		watchdog_clear_first <= #2 req == 2'h3 && !coreHold;
		watchdog_clear_second <= #2 req == 2'h3 && !coreHold;
	end
endmodule // wdhrc_core_model

// file: verif/wdhrc_watchdog_halt_reset_ctrl_test.sv
// Bench for the watchdog, halt and reset block
`timescale 1ns/1ns
module wdhrc_watchdog_halt_reset_ctrl_test;
	logic sys_clk = 1'h0, arst_n = 1'h0, ext_reset_pin_n = 1'h1, optWdtEnable = 1'h1;
	logic optWdtRcOsc = 1'h1, optDualClear = 1'h0, wdtOscTick = 1'h1, regWrEn = 1'h0;
	logic stackFull = 1'h0, haltInstr, watchdog_clear_single, watchdog_clear_first;
	logic watchdog_clear_second, timeout_flag, powerdown_flag, halted, sysClkRun, coreHold;
	logic chipReset, warmReset, cfgLoad, intResponse, resumeNext;
	logic [7:0] regAddr = 8'h09, regWrData = 8'h00, optPortWake = 8'h00, portA = 8'hff, v;
	logic [7:0] regRdData, watchdog_select_reg, timer_control_reg, portDataReset, portDirReset;
	logic [1:0] intReqFlags = 2'h0, intEnable = 2'h0, req = 2'h0;
	int mismatches = 0, checked = 0, cyc = 0, seed = 32'h5690, i;
	wdhrc_watchdog_halt_reset_ctrl dut (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.ext_reset_pin_n(ext_reset_pin_n),
		.optWdtEnable(optWdtEnable),
		.optWdtRcOsc(optWdtRcOsc),
		.optDualClear(optDualClear),
		.optPortWake(optPortWake),
		.wdtOscTick(wdtOscTick),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrEn(regWrEn),
		.watchdog_clear_single(watchdog_clear_single),
		.watchdog_clear_first(watchdog_clear_first),
		.watchdog_clear_second(watchdog_clear_second),
		.haltInstr(haltInstr),
		.intReqFlags(intReqFlags),
		.intEnable(intEnable),
		.stackFull(stackFull),
		.portA(portA),
		.regRdData(regRdData),
		.timeout_flag(timeout_flag),
		.powerdown_flag(powerdown_flag),
		.halted(halted),
		.sysClkRun(sysClkRun),
		.coreHold(coreHold),
		.chipReset(chipReset),
		.warmReset(warmReset),
		.cfgLoad(cfgLoad),
		.intResponse(intResponse),
		.resumeNext(resumeNext),
		.watchdog_select_reg(watchdog_select_reg),
		.timer_control_reg(timer_control_reg),
		.portDataReset(portDataReset),
		.portDirReset(portDirReset)
	);
	wdhrc_core_model core (
		.sys_clk(sys_clk),
		.coreHold(coreHold),
		.req(req),
		.haltInstr(haltInstr),
		.watchdog_clear_single(watchdog_clear_single),
		.watchdog_clear_first(watchdog_clear_first),
		.watchdog_clear_second(watchdog_clear_second)
	);
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			mismatches++;
			report_and_stop;
		end
	end
	task tick;
		@(posedge sys_clk);
		#2;
	endtask
	task check(input string n, input logic [7:0] e, g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task report_and_stop;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function logic sig(input int w);
		return w == 0 ? !coreHold : w == 1 ? chipReset : warmReset;
	endfunction
	function logic [7:0] fl;
		return {6'h00, timeout_flag, powerdown_flag};
	endfunction
	// Bound for a time-out: fixed stage times the prescaler, one tick a cycle
	function int tout(input int sel);
		return (256 << sel) + 16;
	endfunction
	task waitq(input int w, lim);
		for (int n = 0; n < lim && sig(w) !== 1'h1; n++)
			tick;
		check("wait", 8'h01, {7'h00, sig(w)});
	endtask
	task op(input logic [1:0] r);
		req = r;
		tick;
		req = 2'h0;
		tick;
	endtask
	task wr(input logic [7:0] d);
		regWrData = d;
		regWrEn = 1'h1;
		tick;
		regWrEn = 1'h0;
	endtask
	initial
	begin
		repeat (8) tick;
		arst_n = 1'h1;
		waitq(0, 1100);
		check("flags", 8'h00, fl());
		check("watchdog_select", 8'h07, regRdData);
		v = 8'($random(seed)) & 8'hf8;
		wr(v);
		check("user", v, regRdData);
		regAddr = 8'h0a;
		tick;
		check("unmapped", 8'h00, regRdData);
		regAddr = 8'h09;
		for (i = 0; i < 6; i++)
		begin
			repeat (150 + ($random(seed) & 63)) tick;
			check("run", 8'h00, {7'h00, coreHold});
			op(i < 3 ? 2'h2 : i < 5 ? 2'h3 : 2'h2);
			optDualClear = i > 1;
		end
		waitq(1, tout(0));
		check("cfg", 8'h01, {7'h00, cfgLoad});
		check("dir", 8'hff, portDirReset);
		check("timer_control_reg", 8'h08, timer_control_reg);
		waitq(0, 1100);
		check("flags", 8'h02, fl());
		check("watchdog_select", 8'h07, regRdData);
		wr(v | 8'h03);
		i = $random(seed) & 7;
		optPortWake = 8'h01 << i;
		op(2'h1);
		check("halt", 8'h01, fl());
		check("clk", 8'h00, {7'h00, sysClkRun});
		portA[i] = 1'h0;
		waitq(0, 1100);
		check("next", 8'h01, {7'h00, resumeNext});
		portA = 8'hff;
		op(2'h1);
		waitq(2, tout(3));
		waitq(0, 1100);
		check("warm", 8'h03, fl());
		check("keep", v | 8'h03, regRdData);
		op(2'h1);
		ext_reset_pin_n = 1'h0;
		tick;
		ext_reset_pin_n = 1'h1;
		waitq(0, 1100);
		check("ext", 8'h01, fl());
		intEnable = 2'h3;
		op(2'h1);
		intReqFlags = 2'h1;
		waitq(0, 1100);
		check("serve", 8'h01, {7'h00, intResponse});
		intReqFlags = 2'h0;
		optWdtEnable = 1'h0;
		wr(8'h00);
		repeat (600) tick;
		check("off", 8'h00, {7'h00, coreHold});
		report_and_stop;
	end
endmodule // wdhrc_watchdog_halt_reset_ctrl_test

// file: verilog/wdhrc_defs.vh
// Constants for the watchdog, halt and reset sequencing block
`ifndef WDHRC_DEFS_VH
`define WDHRC_DEFS_VH
`define WDHRC_WATCHDOG_SELECT_ADDR 8'h09
`define WDHRC_WATCHDOG_SELECT_RST 8'h07
`define WDHRC_TIMER_CONTROL_REG_RST 8'h08
`define WDHRC_PORT_RST 8'hff
`define WDHRC_DIV_SEL_MSB 2
`define WDHRC_SST_CYCLES 1024
`define WDHRC_CFG_CYCLES 16
`define WDHRC_INSTR_DIV 4
`define WDHRC_FIXED_STAGES 8
`endif

// file: verilog/wdhrc_watchdog_halt_reset_ctrl.v
// Watchdog, halt/wake and reset sequencing logic of a small microcontroller
// Function
// - Watchdog clock: RC oscillator or instruction clock
// - Disabled watchdog ignores clears and does not count; halt and reset pin still zero it
// - Fixed divide-by-256 stage precedes prescaler
// - Select bits 2..0 choose 1:1 to 1:128
// - Bit 3 and high nibble are user flags
// - Normal overflow: chip reset, set time-out
// - Overflow in halt: warm reset, PC/SP only
// - Reset pin, clear, halt clear watchdog
// - Option picks single or dual clear mode
// - Instruction-clock watchdog stops during halt
// - Halt stops system clock, keeps state
// - Halt restarts RC-clocked watchdog from zero
// - Power-down and time-out flag set/clear causes
// - Wake on reset, interrupt, port A, overflow
// - Port or blocked interrupt resumes next instruction
// - Pending flag at halt cannot wake
// - 1024-cycle dummy period after wake
// - Start-up timer 1024 cycles on reset
// - Extra option-load delay on cold resets
// - Flag values per reset cause
// - Chip reset state of core and watchdog
// - Register reset values, warm reset keeps
// - RC oscillator free-running, option disables
`timescale 1ns/1ns
`include "wdhrc_defs.vh"
module wdhrc_watchdog_halt_reset_ctrl (
	sys_clk,
	arst_n,
	ext_reset_pin_n,
	optWdtEnable,
	optWdtRcOsc,
	optDualClear,
	optPortWake,
	wdtOscTick,
	regAddr,
	regWrData,
	regWrEn,
	watchdog_clear_single,
	watchdog_clear_first,
	watchdog_clear_second,
	haltInstr,
	intReqFlags,
	intEnable,
	stackFull,
	portA,
	regRdData,
	timeout_flag,
	powerdown_flag,
	halted,
	sysClkRun,
	coreHold,
	chipReset,
	warmReset,
	cfgLoad,
	intResponse,
	resumeNext,
	watchdog_select_reg,
	timer_control_reg,
	portDataReset,
	portDirReset
);
	input wire sys_clk;
	input wire arst_n;
	input wire ext_reset_pin_n;
	input wire optWdtEnable;
	input wire optWdtRcOsc;
	input wire optDualClear;
	input wire [7:0] optPortWake;
	input wire wdtOscTick;
	input wire [7:0] regAddr;
	input wire [7:0] regWrData;
	input wire regWrEn;
	input wire watchdog_clear_single;
	input wire watchdog_clear_first;
	input wire watchdog_clear_second;
	input wire haltInstr;
	input wire [1:0] intReqFlags;
	input wire [1:0] intEnable;
	input wire stackFull;
	input wire [7:0] portA;
	output wire [7:0] regRdData;
	output wire timeout_flag;
	output wire powerdown_flag;
	output wire halted;
	output wire sysClkRun;
	output wire coreHold;
	output wire chipReset;
	output wire warmReset;
	output wire cfgLoad;
	output reg intResponse;
	output reg resumeNext;
	output wire [7:0] watchdog_select_reg;
	output wire [7:0] timer_control_reg;
	output wire [7:0] portDataReset;
	output wire [7:0] portDirReset;

	localparam ST_CFG = 4'b0001;
	localparam ST_SST = 4'b0010;
	localparam ST_RUN = 4'b0100;
	localparam ST_HALT = 4'b1000;

	reg [3:0] state_q;
	reg [7:0] watchdog_select_q;
	reg [7:0] timer_control_reg_q;
	reg toFlag_q;
	reg pdFlag_q;
	reg [1:0] instrDiv_q;
	reg [7:0] fixedDiv_q;
	reg [7:0] prescale_q;
	reg firstSeen_q;
	reg secondSeen_q;
	reg [10:0] delay_q;
	reg [7:0] portA_q;
	reg [1:0] wakeMask_q;
	reg wakeIntr_q;
	reg wakeNext_q;
	reg pinLow_q;
	reg warm_q;
	reg cold_q;

	// Prescaler overflow point for a division ratio of 2^sel
	function prescaleDone;
		input [7:0] cnt;
		input [2:0] sel;
		begin
			prescaleDone = (cnt == ((8'h01 << sel) - 8'h01));
		end
	endfunction

	wire running = (state_q == ST_RUN);
	wire inHalt = (state_q == ST_HALT);
	wire instrTick = (instrDiv_q == 2'h3) & ~inHalt;
	wire rcTick = wdtOscTick & optWdtRcOsc;
	wire wdtTick = optWdtEnable & (optWdtRcOsc ? rcTick : instrTick) &
		(running | inHalt);
	wire fixedWrap = (fixedDiv_q == 8'hff);
	wire overflow = wdtTick & fixedWrap &
		prescaleDone(prescale_q, watchdog_select_q[`WDHRC_DIV_SEL_MSB:0]);
	wire clrSingle = optWdtEnable & ~optDualClear & watchdog_clear_single & running;
	wire clrDual = optWdtEnable & optDualClear & running &
		((watchdog_clear_first & (secondSeen_q | watchdog_clear_second)) |
		(watchdog_clear_second & firstSeen_q));
	wire clrCmd = clrSingle | clrDual;
	wire haltGo = running & haltInstr;
	wire pinFall = ~ext_reset_pin_n;
	wire [7:0] portFall = portA_q & ~portA & optPortWake;
	wire intWake = |(intReqFlags & ~wakeMask_q);
	wire portWake = |portFall;
	wire wake = inHalt & (intWake | portWake) & ~pinFall & ~overflow;
	wire intServe = intWake & |(intReqFlags & intEnable) & ~stackFull;

	assign regRdData = (regAddr == `WDHRC_WATCHDOG_SELECT_ADDR) ? watchdog_select_q : 8'h00;
	assign timeout_flag = toFlag_q;
	assign powerdown_flag = pdFlag_q;
	assign halted = inHalt;
	assign sysClkRun = ~inHalt;
	assign coreHold = ~running;
	assign chipReset = cold_q;
	assign warmReset = warm_q;
	assign cfgLoad = (state_q == ST_CFG);
	assign watchdog_select_reg = watchdog_select_q;
	assign timer_control_reg = timer_control_reg_q;
	assign portDataReset = cold_q ? `WDHRC_PORT_RST : 8'h00;
	assign portDirReset = cold_q ? `WDHRC_PORT_RST : 8'h00;

	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= ST_CFG;
			watchdog_select_q <= `WDHRC_WATCHDOG_SELECT_RST;
			timer_control_reg_q <= `WDHRC_TIMER_CONTROL_REG_RST;
			toFlag_q <= 1'b0;
			pdFlag_q <= 1'b0;
			instrDiv_q <= 2'h0;
			fixedDiv_q <= 8'h00;
			prescale_q <= 8'h00;
			firstSeen_q <= 1'b0;
			secondSeen_q <= 1'b0;
			delay_q <= 11'h000;
			portA_q <= 8'hff;
			wakeMask_q <= 2'h0;
			wakeIntr_q <= 1'b0;
			wakeNext_q <= 1'b0;
			pinLow_q <= 1'b0;
			warm_q <= 1'b0;
			cold_q <= 1'b1;
			intResponse <= 1'b0;
			resumeNext <= 1'b0;
		end
		else
		begin
			portA_q <= portA;
			pinLow_q <= pinFall;
			warm_q <= 1'b0;
			intResponse <= 1'b0;
			resumeNext <= 1'b0;
			instrDiv_q <= inHalt ? instrDiv_q : instrDiv_q + 2'h1;
			if (pinFall)
			begin
				// Pin held low keeps sequencer, watchdog and registers in reset; flags change only if halted
				state_q <= ST_CFG;
				cold_q <= 1'b1;
				watchdog_select_q <= `WDHRC_WATCHDOG_SELECT_RST;
				timer_control_reg_q <= `WDHRC_TIMER_CONTROL_REG_RST;
				fixedDiv_q <= 8'h00;
				prescale_q <= 8'h00;
				firstSeen_q <= 1'b0;
				secondSeen_q <= 1'b0;
				delay_q <= 11'h000;
				// A reset is not a wake-up, so no resume pulse may follow it
				wakeIntr_q <= 1'b0;
				wakeNext_q <= 1'b0;
				if (inHalt)
				begin
					toFlag_q <= 1'b0;
					pdFlag_q <= 1'b1;
				end
			end
			else
			begin
				if (running & regWrEn & (regAddr == `WDHRC_WATCHDOG_SELECT_ADDR))
					watchdog_select_q <= regWrData;
				if (haltGo | clrCmd)
				begin
					fixedDiv_q <= 8'h00;
					prescale_q <= 8'h00;
					firstSeen_q <= 1'b0;
					secondSeen_q <= 1'b0;
					toFlag_q <= 1'b0;
					pdFlag_q <= haltGo;
				end
				else
				begin
					if (optWdtEnable & optDualClear & running)
					begin
						firstSeen_q <= firstSeen_q | watchdog_clear_first;
						secondSeen_q <= secondSeen_q | watchdog_clear_second;
					end
					if (overflow)
					begin
						fixedDiv_q <= 8'h00;
						prescale_q <= 8'h00;
					end
					else if (wdtTick)
					begin
						fixedDiv_q <= fixedDiv_q + 8'h01;
						if (fixedWrap)
							prescale_q <= prescale_q + 8'h01;
					end
				end
				case (state_q)
					ST_CFG:
					begin
						cold_q <= 1'b1;
						delay_q <= delay_q + 11'h001;
						if (delay_q == `WDHRC_CFG_CYCLES - 1)
						begin
							delay_q <= 11'h000;
							state_q <= ST_SST;
						end
					end
					ST_SST:
					begin
						cold_q <= 1'b0;
						delay_q <= delay_q + 11'h001;
						if (delay_q == `WDHRC_SST_CYCLES - 1)
						begin
							delay_q <= 11'h000;
							state_q <= ST_RUN;
							intResponse <= wakeIntr_q;
							resumeNext <= wakeNext_q;
							wakeIntr_q <= 1'b0;
							wakeNext_q <= 1'b0;
						end
					end
					ST_RUN:
					begin
						// Clear or halt in the same cycle wins over a time-out
						if (overflow & ~clrCmd & ~haltGo)
						begin
							toFlag_q <= 1'b1;
							state_q <= ST_CFG;
							cold_q <= 1'b1;
							watchdog_select_q <= `WDHRC_WATCHDOG_SELECT_RST;
							timer_control_reg_q <= `WDHRC_TIMER_CONTROL_REG_RST;
						end
						else if (haltGo)
						begin
							state_q <= ST_HALT;
							wakeMask_q <= intReqFlags;
						end
					end
					ST_HALT:
					begin
						if (overflow)
						begin
							toFlag_q <= 1'b1;
							pdFlag_q <= 1'b1;
							warm_q <= 1'b1;
							state_q <= ST_SST;
						end
						else if (wake)
						begin
							wakeIntr_q <= ~portWake & intServe;
							wakeNext_q <= portWake | ~intServe;
							state_q <= ST_SST;
						end
					end
					default:
						state_q <= ST_CFG;
				endcase
			end
		end
	end
endmodule // wdhrc_watchdog_halt_reset_ctrl
